// ===== verilog/gpio_port_defs.svh
// gpio_port_defs.svh: offsets, field codes and reset values of the gpio port
// assumes inclusion by bare name from the design modules and the testbench
// What this block does
// - reset leaves every pin floating input: config 01b, mode 00b, no alternates.
// - mode 11 selects output at the fastest speed grade, 50 MHz.
// - general output drives the pin from the last written output latch bit.
// - open-drain drives low for latch 0, floats for 1, never high.
// - push-pull drives low for latch 0 and high for latch 1.
// - input sample captures pin level every clock in input (except analog), output, alternate modes.
// - set/clear or clear-only writes change only latch bits written as 1.
// - bidirectional alternate function keeps the input path floating and sampling.
// - alternate output drives the pin from the peripheral, not the latch.
// - alternate output with disabled peripheral gives an unspecified level.
// - remap moves a function to its alternate pin and off its default.
// - after the lock sequence, configuration writes to pins in the lock mask are ignored until reset.
// - input mode: driver off, receiver on except for analog, pulls only for pulled settings.
// - general output: receiver and pulls off; latch reads last written value.
// - alternate mode: driver from peripheral, receiver on, pulls off.
// - analog: driver and pulls off, receiver forced 0, sample reads 0.
// - enabled usb function takes its two data pins regardless of configuration.
// - mode 00 input, 01 output 10 MHz, 10 output 2 MHz.
// - output config 00 gp push-pull, 01 gp open-drain, 10/11 alternate.
// - input config 00 analog, 01 floating, 10/11 pulled: pull-up for latch 1, pull-down for latch 0.
// - set bit wins over clear bit in one set/clear write.
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH
`define GPIO_PINS      16
`define APB_AW         8
`define OFS_CFG_LO     8'h00
`define OFS_CFG_HI     8'h04
`define OFS_SAMPLE     8'h08
`define OFS_LATCH      8'h0c
`define OFS_SET_CLR    8'h10
`define OFS_CLR        8'h14
`define OFS_LOCK       8'h18
`define OFS_REMAP      8'h1c
`define CFG_RST        4'h4
`define MODE_IN        2'h0
`define MODE_OUT_10M   2'h1
`define MODE_OUT_2M    2'h2
`define MODE_OUT_50M   2'h3
`define IN_ANALOG      2'h0
`define IN_FLOAT       2'h1
`define IN_PULL_DN     2'h2
`define IN_PULL_UP     2'h3
`define OUT_GP_PP      2'h0
`define OUT_GP_OD      2'h1
`define OUT_AF_PP      2'h2
`define OUT_AF_OD      2'h3
`define LOCK_KEY_BIT   16
`define USB_DM_DEFAULT 11
`define USB_DP_DEFAULT 12
`endif

// ===== verilog/gpio_port_pkg.sv
// gpio_port_pkg: types shared by the port and its pin cells
// assumes the constants header is on the include path
package gpio_port_pkg;
    // per-pin configuration nibble
    typedef struct packed {
        logic [1:0] pin_config_field;
        logic [1:0] mode;
    } pin_cfg_s;
    // pad controls of one pin
    typedef struct packed {
        logic       out;
        logic       oe;
        logic       pu;
        logic       pd;
        logic       rx_en;
        logic [1:0] speed;
    } pad_s;
    // lock key sequence, one-hot
    typedef enum logic [3:0] {
        LK_IDLE = 4'h1,
        LK_ONE  = 4'h2,
        LK_ZERO = 4'h4,
        LK_DONE = 4'h8
    } lock_state_e;
endpackage

// ===== verilog/gpio_pin_cell.sv
// gpio_pin_cell: pad control and input sampling of one port pin
// assumes pin_in is asynchronous and all other inputs share core_clk_in
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module gpio_pin_cell
    import gpio_port_pkg::*;
(
    // clock and reset
    input  wire logic     core_clk_in,
    input  wire logic     rst_in,
    // control from the register file
    input  wire pin_cfg_s cfg_in,
    input  wire logic     latch_in,
    input  wire logic     af_val_in,
    // transceiver takeover
    input  wire logic     usb_sel_in,
    input  wire logic     usb_val_in,
    input  wire logic     usb_oe_in,
    // pad
    input  wire logic     pin_in,
    output pad_s          pad_out,
    output logic          sample_out,
    output logic          level_out
);
    logic sync_a;
    pad_s next_pad;

    // mode decode
    wire is_in  = (cfg_in.mode == `MODE_IN);
    wire analog = is_in && (cfg_in.pin_config_field == `IN_ANALOG);
    wire pulled = is_in && (cfg_in.pin_config_field[1] == 1'b1);
    wire is_af  = !is_in && (cfg_in.pin_config_field[1] == 1'b1);
    wire is_od  = !is_in && (cfg_in.pin_config_field[0] == 1'b1);
    wire drv    = is_af ? af_val_in : latch_in;

    // next pad controls
    always_comb
    begin
        next_pad = '0;
        next_pad.speed = cfg_in.mode;
        if (usb_sel_in)
        begin
            next_pad.out   = usb_val_in;
            next_pad.oe    = usb_oe_in;
            next_pad.rx_en = 1'b1;
        end
        else if (is_in)
        begin
            next_pad.pu    = pulled && latch_in;
            next_pad.pd    = pulled && !latch_in;
            next_pad.rx_en = !analog;
        end
        else
        begin
            next_pad.out   = is_od ? 1'b0 : drv;
            next_pad.oe    = is_od ? !drv : 1'b1;
            next_pad.rx_en = is_af;
        end
    end

    // two-stage sync, then sample and pad registers
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            sync_a     <= 1'b0;
            level_out  <= 1'b0;
            sample_out <= 1'b0;
            pad_out    <= '0;
        end
        else
        begin
            sync_a     <= pin_in;
            level_out  <= sync_a;
            sample_out <= (analog && !usb_sel_in) ? 1'b0 : level_out;
            pad_out    <= next_pad;
        end
    end
endmodule // gpio_pin_cell

// ===== verilog/gpio_port_pin_control.sv
// gpio_port_pin_control: sixteen-pin gpio port with an apb register file
// assumes an apb master on core_clk_in and pads resolved outside
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module gpio_port_pin_control
    import gpio_port_pkg::*;
#(
    parameter int USB_DM_PIN = `USB_DM_DEFAULT,
    parameter int USB_DP_PIN = `USB_DP_DEFAULT
)(
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    // apb slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [`APB_AW-1:0]     paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output logic [31:0]                 prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // pads
    input  wire logic [`GPIO_PINS-1:0]  pin_in,
    output logic [`GPIO_PINS-1:0]       pin_out,
    output logic [`GPIO_PINS-1:0]       pin_oe_out,
    output logic [`GPIO_PINS-1:0]       pull_up_out,
    output logic [`GPIO_PINS-1:0]       pull_dn_out,
    output logic [`GPIO_PINS-1:0]       rx_en_out,
    output logic [2*`GPIO_PINS-1:0]     speed_out,
    // peripheral alternate functions
    input  wire logic [`GPIO_PINS-1:0]  af_out_in,
    output logic [`GPIO_PINS-1:0]       af_in_out,
    // usb transceiver
    input  wire logic                   usb_en_in,
    input  wire logic [1:0]             usb_tx_in,
    input  wire logic [1:0]             usb_tx_oe_in,
    output logic [1:0]                  usb_rx_out
);
    localparam int PINS = `GPIO_PINS;
    localparam int HALF = PINS / 2;

    pin_cfg_s          cfg [PINS];
    pad_s              pad [PINS];
    logic [PINS-1:0]   latch;
    logic [PINS-1:0]   remap;
    logic [PINS-1:0]   lock_val;
    lock_state_e       lock_state;
    lock_state_e       next_lock_state;
    logic [PINS-1:0]   next_latch;
    logic [PINS-1:0]   sample;
    logic [PINS-1:0]   level;
    logic [PINS-1:0]   af_val;
    logic [PINS-1:0]   af_in_next;
    logic [4*PINS-1:0] cfg_flat;
    logic [4*PINS-1:0] lock_nib;
    logic [PINS-1:0]   is_in;
    logic [PINS-1:0]   is_an;
    logic [PINS-1:0]   is_od;
    logic [PINS-1:0]   is_gp_pp;
    logic [PINS-1:0]   is_af_pp;

    // address match, one function for every decode
    function automatic logic hit(input logic [`APB_AW-1:0] a,
                                 input logic [`APB_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // latch update: clear first, then set so set wins
    function automatic logic [PINS-1:0] set_clr(input logic [PINS-1:0] cur,
                                                input logic [PINS-1:0] s,
                                                input logic [PINS-1:0] c);
        set_clr = (cur & ~c) | s;
    endfunction

    // apb phase and decode
    wire access    = psel_in && penable_in;
    wire fire      = access && pready_out;
    wire wr_fire   = fire && pwrite_in;
    wire sel_lo    = hit(paddr_in, `OFS_CFG_LO);
    wire sel_hi    = hit(paddr_in, `OFS_CFG_HI);
    wire sel_smp   = hit(paddr_in, `OFS_SAMPLE);
    wire sel_lat   = hit(paddr_in, `OFS_LATCH);
    wire sel_sc    = hit(paddr_in, `OFS_SET_CLR);
    wire sel_clr   = hit(paddr_in, `OFS_CLR);
    wire sel_lock  = hit(paddr_in, `OFS_LOCK);
    wire sel_remap = hit(paddr_in, `OFS_REMAP);
    wire mapped    = sel_lo || sel_hi || sel_smp || sel_lat || sel_sc
                     || sel_clr || sel_lock || sel_remap;
    wire wr_cfg_lo = wr_fire && sel_lo;
    wire wr_cfg_hi = wr_fire && sel_hi;
    wire wr_latch  = wr_fire && sel_lat;
    wire wr_setclr = wr_fire && sel_sc;
    wire wr_clr    = wr_fire && sel_clr;
    wire wr_lock   = wr_fire && sel_lock;
    wire wr_remap  = wr_fire && sel_remap;

    // lock state and per-pin freeze mask
    wire              key      = pwdata_in[`LOCK_KEY_BIT];
    wire              same_val = (pwdata_in[PINS-1:0] == lock_val);
    wire              lock_done = (lock_state == LK_DONE);
    wire [PINS-1:0]   locked   = lock_done ? lock_val : '0;

    // read data selection
    wire [31:0] rd_lock  = {15'h0000, lock_done, lock_val};
    wire [31:0] rd_data  = ({32{sel_lo}}    & cfg_flat[31:0])
                         | ({32{sel_hi}}    & cfg_flat[63:32])
                         | ({32{sel_smp}}   & {16'h0000, sample})
                         | ({32{sel_lat}}   & {16'h0000, latch})
                         | ({32{sel_lock}}  & rd_lock)
                         | ({32{sel_remap}} & {16'h0000, remap});

    // apb answer: one wait cycle, data and error with pready
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= access && !pready_out;
            prdata_out  <= (access && !pready_out && !pwrite_in) ? rd_data : 32'h0000_0000;
            pslverr_out <= access && !pready_out && !mapped;
        end
    end

    // output latch with atomic bit set and clear
    always_comb
    begin
        next_latch = latch;
        if (wr_latch)
            next_latch = pwdata_in[PINS-1:0];
        else if (wr_setclr)
            next_latch = set_clr(latch, pwdata_in[PINS-1:0],
                                 pwdata_in[31:16]);
        else if (wr_clr)
            next_latch = set_clr(latch, '0, pwdata_in[PINS-1:0]);
    end

    // lock key sequence: key 1, 0, 1 with an unchanged pin mask
    always_comb
    begin
        case (lock_state)
            LK_IDLE: next_lock_state = (wr_lock && key) ? LK_ONE : LK_IDLE;
            LK_ONE:
            begin
                if (!wr_lock)
                    next_lock_state = LK_ONE;
                else if (!key && same_val)
                    next_lock_state = LK_ZERO;
                else
                    next_lock_state = key ? LK_ONE : LK_IDLE;
            end
            LK_ZERO:
            begin
                if (!wr_lock)
                    next_lock_state = LK_ZERO;
                else
                    next_lock_state = (key && same_val) ? LK_DONE : LK_IDLE;
            end
            LK_DONE: next_lock_state = LK_DONE;
            default: next_lock_state = LK_IDLE;
        endcase
    end

    // latch, remap, lock registers
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            latch      <= '0;
            remap      <= '0;
            lock_val   <= '0;
            lock_state <= LK_IDLE;
            af_in_out  <= '0;
            usb_rx_out <= 2'h0;
        end
        else
        begin
            latch      <= next_latch;
            remap      <= wr_remap ? pwdata_in[PINS-1:0] : remap;
            lock_val   <= (wr_lock && !lock_done) ? pwdata_in[PINS-1:0] : lock_val;
            lock_state <= next_lock_state;
            af_in_out  <= af_in_next;
            usb_rx_out <= {level[USB_DP_PIN], level[USB_DM_PIN]};
        end
    end

    // per-pin configuration, routing and pad cell
    genvar i;
    generate
        for (i = 0; i < PINS; i++)
        begin : g_pin
            localparam int PARTNER = i ^ HALF;
            wire wr_this = (i < HALF) ? wr_cfg_lo : wr_cfg_hi;
            wire usb_sel = usb_en_in && ((i == USB_DM_PIN) || (i == USB_DP_PIN));
            wire usb_idx = (i == USB_DP_PIN);

            // config nibble, frozen once locked
            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                    cfg[i] <= `CFG_RST;
                else if (wr_this && !locked[i])
                    cfg[i] <= pwdata_in[(i % HALF) * 4 +: 4];
            end

            // remap: alternate pin gains the function, default pin loses it
            assign af_val[i]     = remap[PARTNER] ? af_out_in[PARTNER]
                                 : (!remap[i] && af_out_in[i]);
            assign af_in_next[i] = remap[i] ? sample[PARTNER] : sample[i];

            // decode views for checking
            assign cfg_flat[i*4 +: 4] = cfg[i];
            assign lock_nib[i*4 +: 4] = {4{locked[i]}};
            assign is_in[i]    = !usb_sel && (cfg[i].mode == `MODE_IN);
            assign is_an[i]    = !usb_sel && (cfg[i].mode == `MODE_IN)
                                 && (cfg[i].pin_config_field == `IN_ANALOG);
            assign is_od[i]    = !usb_sel && !is_in[i] && cfg[i].pin_config_field[0];
            assign is_gp_pp[i] = !usb_sel && !is_in[i] && (cfg[i].pin_config_field == `OUT_GP_PP);
            assign is_af_pp[i] = !usb_sel && !is_in[i] && (cfg[i].pin_config_field == `OUT_AF_PP);

            // af value passes even when the peripheral is idle
            gpio_pin_cell i_gpio_pin_cell (
                .core_clk_in (core_clk_in),
                .rst_in      (rst_in),
                .cfg_in      (cfg[i]),
                .latch_in    (latch[i]),
                .af_val_in   (af_val[i]),
                .usb_sel_in  (usb_sel),
                .usb_val_in  (usb_tx_in[usb_idx]),
                .usb_oe_in   (usb_tx_oe_in[usb_idx]),
                .pin_in      (pin_in[i]),
                .pad_out     (pad[i]),
                .sample_out  (sample[i]),
                .level_out   (level[i])
            );

            // pad outputs straight from cell flops
            assign pin_out[i]          = pad[i].out;
            assign pin_oe_out[i]       = pad[i].oe;
            assign pull_up_out[i]      = pad[i].pu;
            assign pull_dn_out[i]      = pad[i].pd;
            assign rx_en_out[i]        = pad[i].rx_en;
            assign speed_out[i*2 +: 2] = pad[i].speed;
        end
    endgenerate

    // checks on the port
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_reset;
        $fell(rst_in) |-> (cfg_flat == {PINS{`CFG_RST}}) && (pin_oe_out == '0);
    endproperty
    a_reset: assert property (p_reset) else $error("reset config wrong");
    property p_od;
        1'b1 |=> ((pin_oe_out & pin_out & $past(is_od)) == '0);
    endproperty
    a_od: assert property (p_od) else $error("open drain drove high");
    property p_gp_pp;
        1'b1 |=> (((pin_out ^ $past(latch)) | ~pin_oe_out) & $past(is_gp_pp)) == '0;
    endproperty
    a_gp_pp: assert property (p_gp_pp) else $error("push-pull not from latch");
    property p_af_pp;
        1'b1 |=> ((pin_out ^ $past(af_val)) & $past(is_af_pp)) == '0;
    endproperty
    a_af_pp: assert property (p_af_pp) else $error("af pin not from peripheral");
    property p_in_off;
        1'b1 |=> ((pin_oe_out & $past(is_in)) == '0);
    endproperty
    a_in_off: assert property (p_in_off) else $error("input pin driven");
    property p_analog;
        1'b1 |=> (((sample | rx_en_out | pull_up_out | pull_dn_out) & $past(is_an)) == '0);
    endproperty
    a_analog: assert property (p_analog) else $error("analog pin not quiet");
    property p_sample;
        1'b1 |=> (((sample ^ $past(level)) & ~$past(is_an)) == '0);
    endproperty
    a_sample: assert property (p_sample) else $error("sample missed pin");
    property p_setclr;
        wr_setclr |=> latch == (($past(latch) & ~$past(pwdata_in[31:16]))
                                | $past(pwdata_in[15:0]));
    endproperty
    a_setclr: assert property (p_setclr) else $error("set/clear wrong");
    property p_clr;
        wr_clr |=> latch == ($past(latch) & ~$past(pwdata_in[15:0]));
    endproperty
    a_clr: assert property (p_clr) else $error("clear touched other bits");
    property p_lock;
        (wr_cfg_lo || wr_cfg_hi) |=> ((cfg_flat ^ $past(cfg_flat)) & $past(lock_nib)) == '0;
    endproperty
    a_lock: assert property (p_lock) else $error("locked pin changed");
    property p_remap;
        ((af_val & remap & ~{remap[HALF-1:0], remap[PINS-1:HALF]}) == '0);
    endproperty
    a_remap: assert property (p_remap) else $error("remapped function on default");
    property p_usb;
        usb_en_in |=> (pin_oe_out[USB_DM_PIN] == $past(usb_tx_oe_in[0]))
                      && (pin_out[USB_DP_PIN] == $past(usb_tx_in[1]));
    endproperty
    a_usb: assert property (p_usb) else $error("usb pins not taken over");
    property p_ready;
        (access && !pready_out) |=> pready_out ##1 !pready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer timing wrong");

    // main scenarios
    c_lock_done: cover property (lock_state == LK_ZERO ##1 lock_done);
    c_setclr_both: cover property (wr_setclr && ((pwdata_in[31:16] & pwdata_in[15:0]) != '0));
    c_usb: cover property (usb_en_in ##1 usb_en_in);
    c_remap: cover property (wr_remap && (pwdata_in[PINS-1:0] != '0));
endmodule // gpio_port_pin_control

// ===== testbench/gpio_pad_model.sv
// gpio_pad_model: package pins and outside drivers facing the gpio port
// assumes one clock; each pad level is resolved every cycle
`timescale 1ns/100ps
module gpio_pad_model (
    // clock
    input  wire logic        clk_in,
    // pad controls from the port
    input  wire logic [15:0] drv_in,
    input  wire logic [15:0] oe_in,
    input  wire logic [15:0] pu_in,
    input  wire logic [15:0] pd_in,
    // outside drivers
    input  wire logic [15:0] ext_val_in,
    input  wire logic [15:0] ext_en_in,
    // resolved pad levels
    output logic [15:0]      level_out
);
    logic [15:0] last = 16'h0;
    // floating pads show the inverse of their last level, never a stale copy
    always @(posedge clk_in)
    begin
        last <= level_out;
    end
    // port drive first, then outside drive, then weak pulls
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (oe_in[i]) level_out[i] = drv_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pu_in[i]) level_out[i] = 1'b1;
            else if (pd_in[i]) level_out[i] = 1'b0;
            else level_out[i] = ~last[i];
        end
    end
endmodule // gpio_pad_model

// ===== testbench/test_gpio_port_pin_control.sv
// test_gpio_port_pin_control: apb bench of the sixteen-pin port
// assumes the pad model on the pins and one 100 MHz clock
`timescale 1ns/100ps
`include "gpio_port_defs.svh"
module test_gpio_port_pin_control;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, spd, rnd = 32'h38;
    logic        pready, pslverr, usb_en = 1'b0;
    logic [15:0] pin, pout, poe, pu, pd, rx, af_i, af_o = 16'h0, ext = 16'h0;
    logic [15:0] ext_en = 16'hffff, lat = 16'h0;
    logic [1:0]  usb_tx = 2'h0, usb_oe = 2'h0, usb_rx;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic [63:0] cfg = {2{32'h4444_4444}};
    int          n_fail = 0, checks = 0;
    // clock
    always #5 clk = ~clk;
    gpio_port_pin_control i_gpio_port_pin_control (.core_clk_in(clk), .rst_in(rst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_in(pin), .pin_out(pout), .pin_oe_out(poe), .pull_up_out(pu), .pull_dn_out(pd),
        .rx_en_out(rx), .speed_out(spd), .af_out_in(af_o), .af_in_out(af_i),
        .usb_en_in(usb_en), .usb_tx_in(usb_tx), .usb_tx_oe_in(usb_oe), .usb_rx_out(usb_rx));
    gpio_pad_model i_gpio_pad_model (.clk_in(clk), .drv_in(pout), .oe_in(poe), .pu_in(pu),
        .pd_in(pd), .ext_val_in(ext), .ext_en_in(ext_en), .level_out(pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; a read passes its expected data as d
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        int n;
        n = 0;
        notes.push_back({wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // each answer is matched to the oldest note
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            nt = notes.pop_front();
            check({31'h0, pslverr}, {31'h0, nt[32]});
            if (!nt[33]) check(prdata, nt[31:0]);
        end
    end
    // works out every pad control from cfg, latch, peripherals and usb
    task automatic pads(input logic rmp);
        logic [15:0] oe, out, p_u, p_d, r, lvl, af, smp;
        logic [31:0] sp;
        logic [3:0]  c;
        logic        v;
        rnd = lfsr(rnd);
        af_o <= rnd[15:0];
        ext <= rnd[31:16];
        af = rnd[15:0];
        if (rmp) af[8] = rnd[0];
        for (int i = 0; i < 16; i++)
        begin
            c = cfg[4*i +: 4];
            v = c[3] ? af[i] : lat[i];
            sp[2*i +: 2] = c[1:0];
            oe[i] = c[1:0] != 2'h0 && !(c[2] && v);
            out[i] = oe[i] & v & ~c[2];
            p_u[i] = c[1:0] == 2'h0 && c[3] && lat[i];
            p_d[i] = c[1:0] == 2'h0 && c[3] && !lat[i];
            r[i] = c[1:0] == 2'h0 ? c[3:2] != 2'h0 : c[3];
            if (usb_en && (i == 11 || i == 12))
            begin
                oe[i] = usb_oe[i-11];
                out[i] = usb_oe[i-11] & usb_tx[i-11];
                p_u[i] = 1'b0;
                p_d[i] = 1'b0;
                r[i] = 1'b1;
            end
            lvl[i] = oe[i] ? out[i] : rnd[16+i];
            smp[i] = lvl[i] & (r[i] | c[1:0] != 2'h0);
        end
        repeat (6) @(posedge clk);
        check({16'h0, poe}, {16'h0, oe});
        check({16'h0, poe & pout}, {16'h0, out});
        check({pu, pd}, {p_u, p_d});
        check({16'h0, rx}, {16'h0, r});
        check(spd, sp);
        check({30'h0, usb_rx}, {30'h0, lvl[12:11]});
        apb(1'b0, `OFS_SAMPLE, {16'h0, smp}, 1'b0);
        if (rmp) check({31'h0, af_i[0]}, {31'h0, smp[8]});
        else check({16'h0, af_i}, {16'h0, smp});
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `OFS_CFG_LO, 32'h4444_4444, 1'b0);
        apb(1'b0, `OFS_CFG_HI, 32'h4444_4444, 1'b0);
        apb(1'b0, 8'h20, 32'h0, 1'b1);
        apb(1'b1, `OFS_SAMPLE, 32'hffff, 1'b0);
        pads(1'b0);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            lat = rnd[15:0];
            apb(1'b1, `OFS_LATCH, {16'h0, lat}, 1'b0);
            rnd = lfsr(rnd);
            apb(1'b1, `OFS_SET_CLR, rnd, 1'b0);
            lat = (lat & ~rnd[31:16]) | rnd[15:0];
            apb(1'b0, `OFS_LATCH, {16'h0, lat}, 1'b0);
            rnd = lfsr(rnd);
            apb(1'b1, `OFS_CLR, rnd, 1'b0);
            lat = lat & ~rnd[15:0];
            apb(1'b0, `OFS_LATCH, {16'h0, lat}, 1'b0);
        end
        cfg[31:0] = 32'hfa53_c840;
        apb(1'b1, `OFS_CFG_LO, cfg[31:0], 1'b0);
        repeat (2)
        begin
            rnd = lfsr(rnd);
            lat = rnd[15:0];
            apb(1'b1, `OFS_LATCH, {16'h0, lat}, 1'b0);
            pads(1'b0);
        end
        rnd = lfsr(rnd);
        usb_en <= 1'b1;
        usb_tx <= rnd[1:0];
        usb_oe <= rnd[3:2];
        cfg[63:32] = 32'h4444_3444;
        apb(1'b1, `OFS_CFG_HI, cfg[63:32], 1'b0);
        pads(1'b0);
        usb_en <= 1'b0;
        cfg[63:32] = 32'h4444_444b;
        apb(1'b1, `OFS_CFG_HI, cfg[63:32], 1'b0);
        apb(1'b1, `OFS_REMAP, 32'h1, 1'b0);
        pads(1'b1);
        apb(1'b1, `OFS_LOCK, 32'h0001_0001, 1'b0);
        apb(1'b1, `OFS_LOCK, 32'h0000_0001, 1'b0);
        apb(1'b1, `OFS_LOCK, 32'h0001_0001, 1'b0);
        apb(1'b0, `OFS_LOCK, 32'h0001_0001, 1'b0);
        apb(1'b1, `OFS_CFG_LO, 32'h3333_3333, 1'b0);
        apb(1'b0, `OFS_CFG_LO, 32'h3333_3330, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `OFS_LOCK, 32'h0, 1'b0);
        apb(1'b0, `OFS_CFG_LO, 32'h4444_4444, 1'b0);
        report_and_stop();
    end
    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule // test_gpio_port_pin_control
